// file: dbgc_asserts.sv
// port checker for dbgc_top
// bound onto dbgc_top, one mclk domain
`default_nettype none
module dbgc_asserts
  import dbgc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        cpu_in_error,
  input wire logic        cpu_in_debug,
  input wire logic        breakpoint_hit,
  input wire logic        link_xfer_done,
  input wire logic        error_mode_clear,
  input wire logic        link_reply_req,
  input wire logic        single_step,
  input wire logic        delay_count_run,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic [8:0]  delay_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] rep_q;
  wire logic  wr_w = reg_wr && reg_addr == DBGC_CTRL_ADDR;
  wire logic  rd_w = reg_rd && reg_addr == DBGC_CTRL_ADDR;
  // copy of the reply enables, so reply checks need no register read
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) rep_q <= 2'h0;
    else if (wr_w) rep_q <= reg_wdata[18:17];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_clear_pulse: assert property (wr_w && reg_wdata[19] |=> error_mode_clear)
    else $error("no clear pulse");
  a_err_read: assert property (rd_w |=> reg_rdata[15] == $past(cpu_in_error) && !reg_rdata[19])
    else $error("error bit");
  a_dbg_read: assert property (rd_w |=> reg_rdata[12] == $past(cpu_in_debug))
    else $error("debug bit");
  a_cnt_read: assert property (rd_w |=> reg_rdata[28:20] == $past(delay_count))
    else $error("count field");
  a_step_copy: assert property (wr_w |=> single_step == $past(reg_wdata[16]))
    else $error("step bit");
  a_run_set: assert property (breakpoint_hit && delay_count != 9'h000 |=> delay_count_run)
    else $error("run not set");
  a_xfer_reply: assert property (link_xfer_done && rep_q[0] && !wr_w |->
    ##[1:2] link_reply_req) else $error("no xfer reply");
  a_entry_reply: assert property ($rose(cpu_in_debug) && rep_q[1] && !wr_w |->
    ##[1:2] link_reply_req) else $error("no entry reply");
  c_reply: cover property (link_reply_req);
  c_clear: cover property (error_mode_clear);
  c_run: cover property (delay_count_run && delay_count == 9'h000);
endmodule // dbgc_asserts
bind dbgc_top dbgc_asserts i_dbgc_asserts (.*);
`default_nettype wire

// file: dbgc_core_model.sv
// core model: debug and error state of the processor
// bench pulses go_err, go_dbg and go_run one cycle each
`default_nettype none
module dbgc_core_model (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic go_err,
  input  wire logic go_dbg,
  input  wire logic go_run,
  input  wire logic error_mode_clear,
  input  wire logic step_break,
  output var logic  cpu_in_error,
  output var logic  cpu_in_debug
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge mclk or negedge rstn)
    if (!rstn) {cpu_in_error, cpu_in_debug} <= 2'h0;
    else begin
      cpu_in_error <= go_err | cpu_in_error & ~error_mode_clear;
      // a break request wins over resume, as a real core honours it first
      cpu_in_debug <= go_dbg | step_break | cpu_in_debug & ~go_run;
    end
endmodule // dbgc_core_model
`default_nettype wire

// file: dbgc_pkg.sv
// package for the debug support control block: register map, field layout, types
// assumes a single 40 MHz clock domain and a plain strobe register port
`default_nettype none
package dbgc_pkg;
  localparam logic [31:0] DBGC_CTRL_ADDR   = 32'h90000000;
  localparam int          DBGC_DCNT_LSB    = 20;
  localparam int          DBGC_DCNT_W      = 9;
  localparam int          DBGC_ERRCLR_BIT  = 19;
  localparam int          DBGC_DREPLY_BIT  = 18;
  localparam int          DBGC_BREPLY_BIT  = 17;
  localparam int          DBGC_SSTEP_BIT   = 16;
  localparam int          DBGC_ERRST_BIT   = 15;
  localparam int          DBGC_DUEN_BIT    = 14;
  localparam int          DBGC_BREN_BIT    = 13;
  localparam int          DBGC_INDBG_BIT   = 12;
  localparam int          DBGC_DRUN_BIT    = 11;
  localparam logic [8:0]  DBGC_DCNT_RST    = 9'h000;
  localparam logic [31:0] DBGC_UNMAPPED_RD = 32'h00000000;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dbgc_req_type;

  typedef struct packed {
    logic debug_entry_reply_en;
    logic bus_transfer_reply_en;
    logic single_step;
  } dbgc_ctl_type;

  typedef enum logic [1:0] {DBGC_RUN, DBGC_STEP, DBGC_REENTER} dbgc_step_type;
endpackage
`default_nettype wire

// file: dbgc_step.sv
// single-step sequencer: one instruction on leaving debug mode, then back in
// assumes the core pulses instr_done once per retired instruction
`default_nettype none
module dbgc_step
  import dbgc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic step_en,
  input  wire logic in_debug,
  input  wire logic instr_done,
  output logic      step_break
);
  dbgc_step_type state_q, state_d;
  logic          left_debug;
  logic          in_debug_q;
  assign left_debug = in_debug_q & ~in_debug;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DBGC_RUN:     if (left_debug && step_en) state_d = DBGC_STEP;
      DBGC_STEP:    if (instr_done) state_d = DBGC_REENTER;
      DBGC_REENTER: if (in_debug) state_d = DBGC_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= DBGC_RUN;
      in_debug_q <= 1'b0;
      step_break <= 1'b0;
    end else begin
      state_q    <= state_d;
      in_debug_q <= in_debug;
      step_break <= (state_d == DBGC_REENTER); // RULE_05
    end
  end
endmodule // dbgc_step

// file: dbgc_sync.sv
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to mclk
`default_nettype none
module dbgc_sync
  import dbgc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level
);
  logic meta_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      level  <= 1'b0;
    end else begin
      meta_q <= pin;
      level  <= meta_q;
    end
  end
endmodule // dbgc_sync

// file: dbgc_tb.sv
// bench for dbgc_top with a core model on the far side
// 40 MHz mclk, strobe register port
`default_nettype none
module tb;
  import dbgc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, seen;
  logic        debug_unit_enable_in = 1'b0, debug_break_enable_in = 1'b0;
  logic [6:0]  pl = 7'h00;
  logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, rdat, reg_rdata;
  logic [8:0]  delay_count;
  logic        cpu_in_error, cpu_in_debug, error_mode_clear, step_break, link_reply_req;
  logic        single_step, delay_count_run;
  wire logic   trace_stored, breakpoint_hit, link_xfer_done, cpu_instr_done;
  wire logic   go_err, go_dbg, go_run;
  int          seed = 32'hdd83, miscompares = 0, checks_done = 0, cyc = 0, mreg = 0, i;
  // pulse index: 6 trace, 5 breakpoint, 4 xfer, 3 instr, 2 err, 1 enter, 0 leave
  assign {trace_stored, breakpoint_hit, link_xfer_done, cpu_instr_done,
          go_err, go_dbg, go_run} = pl;
  `define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
  dbgc_top i_dbgc_top (.*);
  dbgc_core_model i_dbgc_core_model (.*);
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin miscompares++; stop_test(); end
  end
  function automatic int expw();
    return mreg & 32'h1ff70800 | int'({cpu_in_error, debug_unit_enable_in,
      debug_break_enable_in, cpu_in_debug}) << 12;
  endfunction
  task automatic wr(input logic [31:0] a, d);
    @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk) reg_wr <= 1'b0;
    #1 if (a == DBGC_CTRL_ADDR) mreg = d;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 rdat = reg_rdata;
  endtask
  task automatic pulse(input int k);
    @(posedge mclk) pl[k] <= 1'b1;
    @(posedge mclk) pl <= 7'h00;
    #1;
  endtask
  // sample once now, then 1 ns after each edge, so a pulse that lands on the
  // last edge of the stimulus task is still seen and no edge races the design
  task automatic watch(input int k);
    seen = k ? step_break : link_reply_req;
    repeat (3) begin
      @(posedge mclk);
      #1 seen |= k ? step_break : link_reply_req;
    end
  endtask
  task automatic chk();
    rd(DBGC_CTRL_ADDR);
    `CHK("ctrl word", expw(), rdat)
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    for (i = 0; i < 24; i++) begin
      {debug_unit_enable_in, debug_break_enable_in} <= 2'($random(seed));
      wr(DBGC_CTRL_ADDR, $random(seed));
      `CHK("single_step", mreg[16], single_step)
      `CHK("delay_count", mreg[28:20], delay_count)
      pulse(i % 3);
      chk();
    end
    $display("random register test done");
    wr(32'h90000004, 32'hffffffff);
    rd(32'h90000004);
    `CHK("unmapped", 0, rdat)
    chk();
    pulse(2);
    rd(DBGC_CTRL_ADDR);
    `CHK("error set", 1, rdat[15])
    wr(DBGC_CTRL_ADDR, 32'h00080000);
    rd(DBGC_CTRL_ADDR);
    `CHK("error cleared", 0, rdat[15])
    $display("error mode test done");
    wr(DBGC_CTRL_ADDR, 32'h00300000);
    pulse(6);
    `CHK("count idle", 3, delay_count)
    pulse(5);
    `CHK("run set", 1, delay_count_run)
    repeat (4) pulse(6);
    `CHK("count floor", 0, delay_count)
    mreg = 32'h00000800;
    chk();
    $display("delay counter test done");
    wr(DBGC_CTRL_ADDR, 32'h00060000);
    pulse(0);
    pulse(1);
    watch(0);
    `CHK("entry reply", 1, seen)
    pulse(4);
    watch(0);
    `CHK("xfer reply", 1, seen)
    wr(DBGC_CTRL_ADDR, 32'h00010000);
    pulse(4);
    watch(0);
    `CHK("no reply", 0, seen)
    pulse(0);
    watch(1);
    `CHK("early break", 0, seen)
    pulse(3);
    watch(1);
    `CHK("step break", 1, seen)
    `CHK("debug again", 1, cpu_in_debug)
    $display("reply and step test done");
    stop_test();
  end
endmodule // tb
`default_nettype wire

// file: dbgc_top.sv
// debug support control: upper fields of the debug control register
// assumes core status inputs are on mclk and the two enable pins are asynchronous
// Operation
// RULE_01 - a 9-bit delay counter in bits 28:20 can be written and read back.
// RULE_02 - writing one to bit 19 pulses an error-mode clear to the core and bit 19 reads zero.
// RULE_03 - bit 18 makes the link send a reply word when the core enters debug mode.
// RULE_04 - bit 17 makes the link send a reply word after each of its bus transfers.
// RULE_05 - bit 16 lets the core run one instruction after leaving debug mode, then break.
// RULE_06 - bit 15 reads one while the core is in error mode.
// RULE_07 - bit 14 reads the synchronised level of the debug unit enable pin.
// RULE_08 - bit 13 reads the synchronised level of the debug break enable pin.
// RULE_09 - while bit 11 is set the counter decrements per stored trace; a breakpoint sets it. Here a breakpoint sets bit 11 only while the counter is nonzero.
// RULE_10 - bit 12 reads one while the core is in debug mode.
// RULE_11 - writes to the status bits are ignored.
//
// Implementation choice: the plain strobed port.
`default_nettype none
module dbgc_top
  import dbgc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        debug_unit_enable_in,
  input  wire logic        debug_break_enable_in,
  input  wire logic        cpu_in_error,
  input  wire logic        cpu_in_debug,
  input  wire logic        cpu_instr_done,
  input  wire logic        trace_stored,
  input  wire logic        breakpoint_hit,
  input  wire logic        link_xfer_done,
  output logic             error_mode_clear,
  output logic             step_break,
  output logic             link_reply_req,
  output logic             single_step,
  output logic             delay_count_run,
  output logic      [8:0]  delay_count
);
  dbgc_req_type req;
  dbgc_ctl_type ctl_q, ctl_d;
  logic         sel, wr_hit, rd_hit;
  logic         duen_lvl, bren_lvl;
  logic [8:0]   dcnt_q, dcnt_d;
  logic         drun_q, drun_d;
  logic         in_debug_q;
  logic         dbg_entry;
  logic         step_brk;
  logic [31:0]  rd_word;
  logic         reply_d;

  assign req    = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign sel    = (req.addr == DBGC_CTRL_ADDR);
  assign wr_hit = req.wr & sel;
  assign rd_hit = req.rd & sel;

  dbgc_sync u_sync_duen (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   (debug_unit_enable_in),
    .level (duen_lvl)
  );
  dbgc_sync u_sync_bren (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   (debug_break_enable_in),
    .level (bren_lvl)
  );

  dbgc_step u_step (
    .mclk       (mclk),
    .rstn       (rstn),
    .step_en    (ctl_q.single_step),
    .in_debug   (cpu_in_debug),
    .instr_done (cpu_instr_done),
    .step_break (step_brk)
  );

  assign ctl_d = wr_hit ? '{debug_entry_reply_en:  req.wdata[DBGC_DREPLY_BIT],
                            bus_transfer_reply_en: req.wdata[DBGC_BREPLY_BIT],
                            single_step:           req.wdata[DBGC_SSTEP_BIT]}
                        : ctl_q;

  // software write wins over the decrement; a breakpoint set wins over a software clear
  assign dcnt_d = wr_hit ? req.wdata[DBGC_DCNT_LSB +: DBGC_DCNT_W] // RULE_01
                : (drun_q && trace_stored && dcnt_q != 9'h000) ? dcnt_q - 9'h001 // RULE_09
                : dcnt_q;
  assign drun_d = (breakpoint_hit && dcnt_q != 9'h000) ? 1'b1 // RULE_09
                : wr_hit ? req.wdata[DBGC_DRUN_BIT]
                : drun_q;

  assign dbg_entry = cpu_in_debug & ~in_debug_q;
  assign reply_d   = (ctl_q.debug_entry_reply_en & dbg_entry) // RULE_03
                   | (ctl_q.bus_transfer_reply_en & link_xfer_done); // RULE_04

  // status bits come only from live state, so writes there have no effect
  always_comb begin
    rd_word = DBGC_UNMAPPED_RD;
    rd_word[DBGC_DCNT_LSB +: DBGC_DCNT_W] = dcnt_q; // RULE_01
    rd_word[DBGC_ERRCLR_BIT] = 1'b0; // RULE_02
    rd_word[DBGC_DREPLY_BIT] = ctl_q.debug_entry_reply_en;
    rd_word[DBGC_BREPLY_BIT] = ctl_q.bus_transfer_reply_en;
    rd_word[DBGC_SSTEP_BIT]  = ctl_q.single_step;
    rd_word[DBGC_ERRST_BIT]  = cpu_in_error; // RULE_06
    rd_word[DBGC_DUEN_BIT]   = duen_lvl; // RULE_07
    rd_word[DBGC_BREN_BIT]   = bren_lvl; // RULE_08
    rd_word[DBGC_INDBG_BIT]  = cpu_in_debug; // RULE_10
    rd_word[DBGC_DRUN_BIT]   = drun_q;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl_q      <= '0;
      dcnt_q     <= DBGC_DCNT_RST;
      drun_q     <= 1'b0;
      in_debug_q <= 1'b0;
    end else begin
      ctl_q      <= ctl_d; // RULE_11
      dcnt_q     <= dcnt_d;
      drun_q     <= drun_d;
      in_debug_q <= cpu_in_debug;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata        <= DBGC_UNMAPPED_RD;
      error_mode_clear <= 1'b0;
      link_reply_req   <= 1'b0;
      step_break       <= 1'b0;
      single_step      <= 1'b0;
      delay_count_run  <= 1'b0;
      delay_count      <= DBGC_DCNT_RST;
    end else begin
      reg_rdata        <= rd_hit ? rd_word : DBGC_UNMAPPED_RD;
      error_mode_clear <= wr_hit & req.wdata[DBGC_ERRCLR_BIT]; // RULE_02
      link_reply_req   <= reply_d;
      step_break       <= step_brk; // RULE_05
      single_step      <= ctl_d.single_step;
      delay_count_run  <= drun_d;
      delay_count      <= dcnt_d;
    end
  end
endmodule // dbgc_top
`default_nettype wire
